// ### logic/rbrm_top.sv
// The APB interface to the registers and the register offsets are this design's own decisions.
`default_nettype none
module rbrm_top (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    input wire rbrm_pkg::rbrm_rx_stat_t rx_stat,
    output logic rx_ready,
    input wire logic tx_sent,
    input wire logic tx_fault,
    output rbrm_pkg::rbrm_mem_t mem,
    output logic tx_request
);
    logic [7:0] cmd_reg;
    logic [7:0] tcr_reg;
    logic [7:0] rcr_reg;
    logic [7:0] data_config_reg;
    logic [7:0] first_reg;
    logic [7:0] end_reg;
    logic [7:0] bnd_reg;
    logic [7:0] cur_reg;
    logic [7:0] isr_reg;
    logic [7:0] imr_reg;
    logic [7:0] miss_reg;
    logic [7:0] rcl_reg;
    logic [7:0] rch_reg;
    logic halted_reg;
    logic rx_gate_reg;
    logic full_reg;
    rbrm_pkg::rbrm_state_t state_reg;
    logic [7:0] page_reg;
    logic [7:0] off_reg;
    logic [15:0] count_reg;
    logic [7:0] next_reg;
    logic [7:0] stat_reg;
    logic [1:0] hidx_reg;
    logic [31:0] rdata_next;
    logic hit_next;
    logic wr_cmd, wr_tcr, wr_isr, wr_bnd, wr_cur, acc, setup;
    logic take, start_pkt, can_rx, pkt_good, set_ovw, set_prx, set_rxe;
    logic [7:0] link_page;
    logic [7:0] isr_set;

    assign setup = psel && !penable;
    assign acc = psel && penable && pready && pwrite;
    assign wr_cmd = acc && paddr == rbrm_pkg::ADDR_CMD;
    assign wr_tcr = acc && paddr == rbrm_pkg::ADDR_TCR;
    assign wr_isr = acc && paddr == rbrm_pkg::ADDR_ISR;
    assign wr_bnd = acc && paddr == rbrm_pkg::ADDR_BND;
    assign wr_cur = acc && paddr == rbrm_pkg::ADDR_CUR;

    // read mux, decoded during the setup cycle so data is ready at access
    always_comb begin
        rdata_next = '0;
        hit_next = 1'b1;
        if (paddr == rbrm_pkg::ADDR_CMD) begin
            rdata_next[7:0] = cmd_reg;
        end else if (paddr == rbrm_pkg::ADDR_TCR) begin
            rdata_next[7:0] = tcr_reg;
        end else if (paddr == rbrm_pkg::ADDR_RCR) begin
            rdata_next[7:0] = rcr_reg;
        end else if (paddr == rbrm_pkg::ADDR_DCR) begin
            rdata_next[7:0] = data_config_reg;
        end else if (paddr == rbrm_pkg::ADDR_FIRST) begin
            rdata_next[7:0] = first_reg;
        end else if (paddr == rbrm_pkg::ADDR_END) begin
            rdata_next[7:0] = end_reg;
        end else if (paddr == rbrm_pkg::ADDR_BND) begin
            rdata_next[7:0] = bnd_reg;
        end else if (paddr == rbrm_pkg::ADDR_CUR) begin
            rdata_next[7:0] = cur_reg;
        end else if (paddr == rbrm_pkg::ADDR_ISR) begin
            rdata_next[7:0] = isr_reg;
        end else if (paddr == rbrm_pkg::ADDR_IMR) begin
            rdata_next[7:0] = imr_reg;
        end else if (paddr == rbrm_pkg::ADDR_MISS) begin
            rdata_next[7:0] = miss_reg;
        end else if (paddr == rbrm_pkg::ADDR_RCL) begin
            rdata_next[7:0] = rcl_reg;
        end else if (paddr == rbrm_pkg::ADDR_RCH) begin
            rdata_next[7:0] = rch_reg;
        end else begin
            hit_next = 1'b0;
        end
    end

    // apb answer: one wait-free access phase after every setup
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            prdata <= setup ? rdata_next : '0;
            pslverr <= setup && !hit_next;
        end
    end

    // plain software-owned configuration bytes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tcr_reg <= rbrm_pkg::REG_RST;
            rcr_reg <= rbrm_pkg::REG_RST;
            data_config_reg <= rbrm_pkg::REG_RST;
            first_reg <= rbrm_pkg::REG_RST;
            end_reg <= rbrm_pkg::REG_RST;
            bnd_reg <= rbrm_pkg::REG_RST;
            imr_reg <= rbrm_pkg::REG_RST;
            rcl_reg <= rbrm_pkg::REG_RST;
            rch_reg <= rbrm_pkg::REG_RST;
        end else if (acc) begin
            if (paddr == rbrm_pkg::ADDR_TCR) tcr_reg <= pwdata[7:0];
            if (paddr == rbrm_pkg::ADDR_RCR) rcr_reg <= pwdata[7:0];
            if (paddr == rbrm_pkg::ADDR_DCR) data_config_reg <= pwdata[7:0];
            if (paddr == rbrm_pkg::ADDR_FIRST) first_reg <= pwdata[7:0];
            if (paddr == rbrm_pkg::ADDR_END) end_reg <= pwdata[7:0];
            if (paddr == rbrm_pkg::ADDR_BND) bnd_reg <= pwdata[7:0];
            if (paddr == rbrm_pkg::ADDR_IMR) imr_reg <= pwdata[7:0];
            if (paddr == rbrm_pkg::ADDR_RCL) rcl_reg <= pwdata[7:0];
            if (paddr == rbrm_pkg::ADDR_RCH) rch_reg <= pwdata[7:0];
        end
    end

    // command byte; request bit drops when the transmit side reports back
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reg <= rbrm_pkg::CMD_RST;
            halted_reg <= 1'b1;
            tx_request <= 1'b0;
        end else begin
            if (wr_cmd) begin
                cmd_reg <= pwdata[7:0];
                if (pwdata[rbrm_pkg::CMD_HALT]) begin
                    halted_reg <= 1'b1;
                end else if (pwdata[rbrm_pkg::CMD_START]) begin
                    halted_reg <= 1'b0;
                end
                tx_request <= pwdata[rbrm_pkg::CMD_TXREQ] && !pwdata[rbrm_pkg::CMD_HALT];
            end else if (tx_sent || tx_fault) begin
                tx_request <= 1'b0;
                cmd_reg[rbrm_pkg::CMD_TXREQ] <= 1'b0;
            end
        end
    end

    // receive gate: a start while looped back holds the local dma off
    // until the transmit config is rewritten
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_gate_reg <= 1'b0;
        end else if (wr_tcr) begin
            rx_gate_reg <= 1'b1;
        end else if (wr_cmd && pwdata[rbrm_pkg::CMD_START]) begin
            rx_gate_reg <= tcr_reg[rbrm_pkg::TCR_LB_HI:rbrm_pkg::TCR_LB_LO] == 2'b00;
        end
    end

    assign can_rx = !halted_reg && rx_gate_reg;
    assign take = rx_valid && rx_ready;
    assign start_pkt = take && state_reg == rbrm_pkg::RBRM_IDLE;
    assign pkt_good = (!(rx_stat.crc_err || rx_stat.align_err) || rcr_reg[rbrm_pkg::RCR_ACC_ERR])
        && (!rx_stat.runt || rcr_reg[rbrm_pkg::RCR_ACC_RUNT]);

    // next page with wrap at the end page, compared on page numbers only
    always_comb begin
        link_page = page_reg + 8'h01;
        if (link_page == end_reg) begin
            link_page = first_reg;
        end
    end

    // status events raised by the receive machine, the transmit side and the halt state
    assign set_ovw = (start_pkt && can_rx && full_reg)
        || (state_reg == rbrm_pkg::RBRM_STORE && take && !rx_last
            && off_reg == rbrm_pkg::PAGE_LAST && link_page == bnd_reg);
    assign set_prx = state_reg == rbrm_pkg::RBRM_STORE && take && rx_last && pkt_good;
    assign set_rxe = state_reg == rbrm_pkg::RBRM_STORE && take && rx_last && !pkt_good;
    always_comb begin
        isr_set = '0;
        isr_set[rbrm_pkg::ISR_PRX] = set_prx;
        isr_set[rbrm_pkg::ISR_PTX] = tx_sent;
        isr_set[rbrm_pkg::ISR_RXE] = set_rxe;
        isr_set[rbrm_pkg::ISR_TXE] = tx_fault;
        isr_set[rbrm_pkg::ISR_OVW] = set_ovw;
        isr_set[rbrm_pkg::ISR_RST] = halted_reg;
    end

    // sticky status flags, write one to clear; a set in the same cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_isr
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    isr_reg[gi] <= 1'b0;
                end else if (isr_set[gi]) begin
                    isr_reg[gi] <= 1'b1;
                end else if (wr_isr && pwdata[gi]) begin
                    isr_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // missed tally: packets dropped at their first byte while running; frozen when halted
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            miss_reg <= rbrm_pkg::REG_RST;
        end else if (start_pkt && !halted_reg && (!rx_gate_reg || full_reg)
                     && miss_reg != rbrm_pkg::MISS_MAX) begin
            miss_reg <= miss_reg + 8'h01;
        end
    end

    // write pointer and full/empty memory of the ring
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur_reg <= rbrm_pkg::REG_RST;
            full_reg <= 1'b0;
        end else if (state_reg == rbrm_pkg::RBRM_HDR && hidx_reg == rbrm_pkg::HDR_LAST) begin
            cur_reg <= next_reg;
            full_reg <= next_reg == bnd_reg;
        end else if (wr_cur) begin
            cur_reg <= pwdata[7:0];
            full_reg <= 1'b0;
        end else if (wr_bnd) begin
            full_reg <= 1'b0;
        end
    end

    // receive machine: store, link pages, then header or reclaim
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= rbrm_pkg::RBRM_IDLE;
            page_reg <= rbrm_pkg::REG_RST;
            off_reg <= rbrm_pkg::REG_RST;
            count_reg <= '0;
            next_reg <= rbrm_pkg::REG_RST;
            stat_reg <= rbrm_pkg::REG_RST;
            hidx_reg <= '0;
            rx_ready <= 1'b0;
            mem <= '0;
        end else begin
            mem.we <= 1'b0;
            rx_ready <= state_reg != rbrm_pkg::RBRM_HDR;
            case (state_reg)
                rbrm_pkg::RBRM_IDLE: begin
                    if (start_pkt) begin
                        if (can_rx && !full_reg) begin
                            mem <= '{1'b1, {cur_reg, rbrm_pkg::HDR_BYTES}, rx_data};
                            page_reg <= cur_reg;
                            off_reg <= rbrm_pkg::HDR_BYTES + 8'h01;
                            count_reg <= 16'h0001;
                            state_reg <= rx_last ? rbrm_pkg::RBRM_IDLE : rbrm_pkg::RBRM_STORE;
                        end else if (!rx_last) begin
                            state_reg <= rbrm_pkg::RBRM_DROP;
                        end
                    end
                end
                rbrm_pkg::RBRM_STORE: begin
                    if (take) begin
                        // trailing crc bytes arrive as data, so they land after the payload
                        mem <= '{1'b1, {page_reg, off_reg}, rx_data};
                        count_reg <= count_reg + 16'h0001;
                        off_reg <= off_reg + 8'h01;
                        if (rx_last) begin
                            next_reg <= off_reg == rbrm_pkg::PAGE_LAST ? link_page
                                : (page_reg + 8'h01 == end_reg ? first_reg
                                   : page_reg + 8'h01);
                            stat_reg <= {4'h0, rx_stat.runt, rx_stat.align_err,
                                         rx_stat.crc_err, pkt_good};
                            hidx_reg <= '0;
                            rx_ready <= !pkt_good;
                            // rejected: cur never moved, so all pages come back
                            state_reg <= pkt_good ? rbrm_pkg::RBRM_HDR
                                : rbrm_pkg::RBRM_IDLE;
                        end else if (off_reg == rbrm_pkg::PAGE_LAST) begin
                            if (link_page == bnd_reg) begin
                                state_reg <= rbrm_pkg::RBRM_DROP;
                            end else begin
                                page_reg <= link_page;
                            end
                        end
                    end
                end
                rbrm_pkg::RBRM_DROP: begin
                    if (take && rx_last) begin
                        state_reg <= rbrm_pkg::RBRM_IDLE;
                    end
                end
                rbrm_pkg::RBRM_HDR: begin
                    // header goes back into the first page at offsets 0..3
                    mem.we <= 1'b1;
                    mem.addr <= {cur_reg, 6'h00, hidx_reg};
                    case (hidx_reg)
                        2'h0: mem.data <= stat_reg;
                        2'h1: mem.data <= next_reg;
                        2'h2: mem.data <= count_reg[7:0];
                        default: mem.data <= count_reg[15:8];
                    endcase
                    hidx_reg <= hidx_reg + 2'h1;
                    if (hidx_reg == rbrm_pkg::HDR_LAST) begin
                        state_reg <= rbrm_pkg::RBRM_IDLE;
                        rx_ready <= 1'b1;
                    end
                end
                default: state_reg <= rbrm_pkg::RBRM_IDLE;
            endcase
        end
    end

    property p_link_wrap;
        @(posedge mclk) disable iff (!rst_n)
        (state_reg == rbrm_pkg::RBRM_STORE && take && !rx_last
         && off_reg == rbrm_pkg::PAGE_LAST && page_reg + 8'h01 == end_reg
         && first_reg != bnd_reg) |=> page_reg == $past(first_reg);
    endproperty
    a_link_wrap: assert property (p_link_wrap) else $error("no wrap at end page");

    property p_link_next;
        @(posedge mclk) disable iff (!rst_n)
        (state_reg == rbrm_pkg::RBRM_STORE && take && !rx_last
         && off_reg == rbrm_pkg::PAGE_LAST && page_reg + 8'h01 != end_reg
         && page_reg + 8'h01 != bnd_reg) |=> page_reg == $past(page_reg) + 8'h01;
    endproperty
    a_link_next: assert property (p_link_next) else $error("page not linked");

    property p_bnd_abort;
        @(posedge mclk) disable iff (!rst_n)
        (state_reg == rbrm_pkg::RBRM_STORE && take && !rx_last
         && off_reg == rbrm_pkg::PAGE_LAST && link_page == bnd_reg)
        |=> state_reg == rbrm_pkg::RBRM_DROP && isr_reg[rbrm_pkg::ISR_OVW]
            && cur_reg == $past(cur_reg);
    endproperty
    a_bnd_abort: assert property (p_bnd_abort) else $error("boundary not honoured");

    property p_no_write_bnd;
        @(posedge mclk) disable iff (!rst_n)
        (mem.we && $past(state_reg) == rbrm_pkg::RBRM_STORE)
        |-> mem.addr[15:8] != bnd_reg || mem.addr[15:8] == cur_reg;
    endproperty
    a_no_write_bnd: assert property (p_no_write_bnd) else $error("wrote boundary page");

    property p_first_offset;
        @(posedge mclk) disable iff (!rst_n)
        (start_pkt && can_rx && !full_reg) |=> mem.we && mem.addr[7:0] == rbrm_pkg::HDR_BYTES;
    endproperty
    a_first_offset: assert property (p_first_offset) else $error("data offset wrong");

    property p_header;
        @(posedge mclk) disable iff (!rst_n)
        set_prx |=> ##1 (mem.we && mem.addr == {cur_reg, 8'h00})
            ##1 (mem.data == next_reg) ##2 cur_reg == $past(next_reg, 3);
    endproperty
    a_header: assert property (p_header) else $error("header sequence wrong");

    property p_reject;
        @(posedge mclk) disable iff (!rst_n)
        set_rxe |=> state_reg == rbrm_pkg::RBRM_IDLE && cur_reg == $past(cur_reg);
    endproperty
    a_reject: assert property (p_reject) else $error("reject did not reclaim");

    property p_miss_halt;
        @(posedge mclk) disable iff (!rst_n)
        halted_reg |=> miss_reg == $past(miss_reg);
    endproperty
    a_miss_halt: assert property (p_miss_halt) else $error("tally moved while halted");

    property p_loop_gate;
        @(posedge mclk) disable iff (!rst_n)
        (wr_cmd && pwdata[rbrm_pkg::CMD_START] && !pwdata[rbrm_pkg::CMD_HALT]
         && tcr_reg[rbrm_pkg::TCR_LB_HI:rbrm_pkg::TCR_LB_LO] != 2'b00)
        |=> !can_rx;
    endproperty
    a_loop_gate: assert property (p_loop_gate) else $error("receive live in loopback");

    property p_isr_clear;
        @(posedge mclk) disable iff (!rst_n)
        (wr_isr && pwdata[7:0] == 8'hFF && isr_set == 8'h00) |=> isr_reg == 8'h00;
    endproperty
    a_isr_clear: assert property (p_isr_clear) else $error("status not cleared");
endmodule
`default_nettype wire

// ### logic/rbrm_pkg.sv
`default_nettype none
package rbrm_pkg;
    // apb register byte addresses
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_TCR = 8'h04;
    localparam logic [7:0] ADDR_RCR = 8'h08;
    localparam logic [7:0] ADDR_DCR = 8'h0C;
    localparam logic [7:0] ADDR_FIRST = 8'h10;
    localparam logic [7:0] ADDR_END = 8'h14;
    localparam logic [7:0] ADDR_BND = 8'h18;
    localparam logic [7:0] ADDR_CUR = 8'h1C;
    localparam logic [7:0] ADDR_ISR = 8'h20;
    localparam logic [7:0] ADDR_IMR = 8'h24;
    localparam logic [7:0] ADDR_MISS = 8'h28;
    localparam logic [7:0] ADDR_RCL = 8'h2C;
    localparam logic [7:0] ADDR_RCH = 8'h30;
    // command register fields
    localparam int CMD_HALT = 0;
    localparam int CMD_START = 1;
    localparam int CMD_TXREQ = 2;
    localparam logic [7:0] CMD_RST = 8'h21;
    // transmit config loopback field (bits 2:1)
    localparam int TCR_LB_HI = 2;
    localparam int TCR_LB_LO = 1;
    // receive config fields
    localparam int RCR_ACC_ERR = 0;
    localparam int RCR_ACC_RUNT = 1;
    // interrupt status bits
    localparam int ISR_PRX = 0;
    localparam int ISR_PTX = 1;
    localparam int ISR_RXE = 2;
    localparam int ISR_TXE = 3;
    localparam int ISR_OVW = 4;
    localparam int ISR_RST = 7;
    // receive status byte fields
    localparam int RST_OK = 0;
    localparam int RST_CRC = 1;
    localparam int RST_ALIGN = 2;
    localparam int RST_RUNT = 3;
    // page layout
    localparam logic [7:0] HDR_BYTES = 8'h04;
    localparam logic [7:0] PAGE_LAST = 8'hFF;
    localparam logic [1:0] HDR_LAST = 2'h3;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] MISS_MAX = 8'hFF;

    typedef enum {RBRM_IDLE, RBRM_STORE, RBRM_DROP, RBRM_HDR} rbrm_state_t;

    // end-of-packet verdict from the receive stream
    typedef struct packed {
        logic runt;
        logic crc_err;
        logic align_err;
    } rbrm_rx_stat_t;

    // byte write toward local buffer memory
    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [7:0] data;
    } rbrm_mem_t;
endpackage
`default_nettype wire

// ### verif/rbrm_mem_model.sv
`default_nettype none
module rbrm_mem_model (
    input wire logic mclk,
    input wire rbrm_pkg::rbrm_mem_t mem
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] m [0:65535];
    int wcnt [0:255];
    // per-page write tally lets the bench prove a page was never touched
    initial begin
        for (int i = 0; i < 256; i++) wcnt[i] = 0;
    end
    // buffer memory never stalls, so each strobe lands in the cycle it is seen
    always @(posedge mclk) begin
        if (mem.we) begin
            m[mem.addr] <= mem.data;
            wcnt[mem.addr[15:8]] <= wcnt[mem.addr[15:8]] + 1;
        end
    end
endmodule
`default_nettype wire

// ### verif/tb_receive_buffer_ring_manager.sv
`default_nettype none
module tb_receive_buffer_ring_manager;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] FIRST = 8'h40;
    localparam logic [7:0] ENDP = 8'h46;
    logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, rx_data = 8'h00, ms;
    logic [31:0] pwdata = 32'h00000000, prdata, r;
    logic pready, pslverr, e, rx_ready, tx_request, txs, resend;
    logic rx_valid = 1'b0, rx_last = 1'b0, tx_sent = 1'b0, tx_fault = 1'b0;
    rbrm_pkg::rbrm_rx_stat_t rx_stat = 3'h0;
    rbrm_pkg::rbrm_mem_t mem;
    logic [7:0] pk [0:2047];
    int n_fail = 0, n_checks = 0, w;
    rbrm_top rbrm_top_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .rx_stat(rx_stat), .rx_ready(rx_ready), .tx_sent(tx_sent), .tx_fault(tx_fault),
        .mem(mem), .tx_request(tx_request));
    rbrm_mem_model rbrm_mem_model_inst (.mclk(mclk), .mem(mem));
    // 250 MHz
    always #2 mclk = ~mclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; the extra edge keeps back-to-back calls from double-driving psel
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        check(r, exp);
    endtask
    // random packet, bytes back to back, each held until rx_ready takes it
    task automatic send(input int len, input logic [2:0] st);
        for (int i = 0; i < len; i++) begin
            pk[i] = 8'($urandom);
            rx_valid <= 1'b1;
            rx_data <= pk[i];
            rx_last <= (i == len - 1);
            rx_stat <= st;
            do @(posedge mclk); while (rx_ready !== 1'b1);
        end
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
    // page after a packet: header plus data rounded up to whole pages, wrapping at the end
    function automatic logic [7:0] next_pg(input logic [7:0] p, input int len);
        for (int i = 0; i < (len + 259) / 256; i++) begin
            p = p + 8'h01;
            if (p == ENDP) p = FIRST;
        end
        return p;
    endfunction
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // a full run is some 3k cycles; this cuts a hang at 100k
    initial begin
        #400000;
        n_fail++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h9D527A63));
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(rbrm_pkg::ADDR_CMD, 32'h00000021);
        rd(rbrm_pkg::ADDR_ISR, 32'h00000080);
        apb(1'b1, 8'h3C, 8'h5A);
        check(e, 1'b1);
        // bring-up in loopback, ring 40..45
        apb(1'b1, rbrm_pkg::ADDR_CMD, 8'h21);
        w = $urandom;
        apb(1'b1, rbrm_pkg::ADDR_DCR, 8'(w));
        rd(rbrm_pkg::ADDR_DCR, {24'h000000, 8'(w)});
        apb(1'b1, rbrm_pkg::ADDR_RCL, 8'h00);
        apb(1'b1, rbrm_pkg::ADDR_RCH, 8'h00);
        apb(1'b1, rbrm_pkg::ADDR_RCR, 8'h00);
        apb(1'b1, rbrm_pkg::ADDR_TCR, 8'h02);
        apb(1'b1, rbrm_pkg::ADDR_BND, FIRST);
        apb(1'b1, rbrm_pkg::ADDR_FIRST, FIRST);
        apb(1'b1, rbrm_pkg::ADDR_END, ENDP);
        apb(1'b1, rbrm_pkg::ADDR_ISR, 8'hFF);
        apb(1'b1, rbrm_pkg::ADDR_IMR, 8'(w));
        apb(1'b1, rbrm_pkg::ADDR_CMD, 8'h61);
        apb(1'b1, rbrm_pkg::ADDR_CUR, FIRST);
        apb(1'b1, rbrm_pkg::ADDR_CMD, 8'h22);
        send(20, 3'h0);
        rd(rbrm_pkg::ADDR_MISS, 32'h00000001);
        check(rbrm_mem_model_inst.wcnt[FIRST], 32'h00000000);
        apb(1'b1, rbrm_pkg::ADDR_TCR, 8'h00);
        // good two-page packet
        send(300, 3'h0);
        for (int i = 0; i < 300; i++) check(rbrm_mem_model_inst.m[16'h4004 + 16'(i)], pk[i]);
        check(rbrm_mem_model_inst.m[16'h4000], 8'h01);
        check(rbrm_mem_model_inst.m[16'h4001], next_pg(FIRST, 300));
        check({rbrm_mem_model_inst.m[16'h4003], rbrm_mem_model_inst.m[16'h4002]}, 300);
        rd(rbrm_pkg::ADDR_CUR, next_pg(FIRST, 300));
        // each error kind rejected and reclaimed, then an alignment error accepted when enabled
        for (int k = 0; k < 3; k++) begin
            send(40, 3'h1 << k);
            rd(rbrm_pkg::ADDR_CUR, 32'h00000042);
        end
        apb(1'b1, rbrm_pkg::ADDR_RCR, 8'h01);
        send(20, 3'h1);
        rd(rbrm_pkg::ADDR_CUR, 32'h00000043);
        // four pages from 43 wrap through the end page
        apb(1'b1, rbrm_pkg::ADDR_BND, 8'h42);
        send(1000, 3'h0);
        check(rbrm_mem_model_inst.m[16'h4500], pk[508]);
        check(rbrm_mem_model_inst.m[16'h4000], pk[764]);
        rd(rbrm_pkg::ADDR_CUR, next_pg(8'h43, 1000));
        // next link would hit the boundary page
        apb(1'b1, rbrm_pkg::ADDR_CMD, 8'h26);
        w = rbrm_mem_model_inst.wcnt[8'h42];
        send(600, 3'h0);
        check(rbrm_mem_model_inst.wcnt[8'h42], w);
        check(rbrm_mem_model_inst.m[16'h4300], 8'h01);
        rd(rbrm_pkg::ADDR_CUR, 32'h00000041);
        apb(1'b0, rbrm_pkg::ADDR_ISR, 8'h00);
        check(r[rbrm_pkg::ISR_OVW], 1'b1);
        // overflow recovery as the driver runs it
        apb(1'b0, rbrm_pkg::ADDR_CMD, 8'h00);
        txs = r[rbrm_pkg::CMD_TXREQ];
        apb(1'b1, rbrm_pkg::ADDR_CMD, 8'h21);
        apb(1'b0, rbrm_pkg::ADDR_MISS, 8'h00);
        ms = r[7:0];
        send(30, 3'h0);
        rd(rbrm_pkg::ADDR_MISS, {24'h000000, ms});
        // shortened settle wait: nothing is in flight on this bench
        repeat (256) @(posedge mclk);
        apb(1'b1, rbrm_pkg::ADDR_RCL, 8'h00);
        apb(1'b1, rbrm_pkg::ADDR_RCH, 8'h00);
        apb(1'b0, rbrm_pkg::ADDR_ISR, 8'h00);
        resend = txs && !r[rbrm_pkg::ISR_PTX] && !r[rbrm_pkg::ISR_TXE];
        apb(1'b1, rbrm_pkg::ADDR_TCR, 8'h04);
        apb(1'b1, rbrm_pkg::ADDR_TCR, 8'h02);
        apb(1'b1, rbrm_pkg::ADDR_CMD, 8'h22);
        send(30, 3'h0);
        rd(rbrm_pkg::ADDR_MISS, {24'h000000, ms + 8'h01});
        apb(1'b1, rbrm_pkg::ADDR_BND, 8'h45);
        apb(1'b1, rbrm_pkg::ADDR_ISR, 8'h10);
        // only the overwrite bit is cleared; rx ok, rx error and halted stay sticky
        rd(rbrm_pkg::ADDR_ISR, 32'h00000085);
        apb(1'b1, rbrm_pkg::ADDR_TCR, 8'h00);
        check(resend, 1'b1);
        if (resend) apb(1'b1, rbrm_pkg::ADDR_CMD, 8'h26);
        @(posedge mclk);
        check(tx_request, 1'b1);
        tx_sent <= 1'b1;
        @(posedge mclk);
        tx_sent <= 1'b0;
        tx_fault <= 1'b1;
        @(posedge mclk);
        tx_fault <= 1'b0;
        check(tx_request, 1'b0);
        rd(rbrm_pkg::ADDR_ISR, 32'h0000008F);
        apb(1'b1, rbrm_pkg::ADDR_ISR, 8'hFF);
        rd(rbrm_pkg::ADDR_ISR, 32'h00000000);
        send(100, 3'h0);
        rd(rbrm_pkg::ADDR_CUR, next_pg(8'h41, 100));
        wrap_up();
    end
endmodule
`default_nettype wire
